//--- verilog/wdt_pkg.sv
package wdt_pkg;

	// Control register location in the special-function register space.
	localparam logic [7:0] WDT_CTRL_ADDR   = 8'hC0;
	localparam logic [7:0] WDT_CTRL_RESET  = 8'h10;

	// Field positions inside the control register.
	localparam int         PRESCALE_MSB    = 7;
	localparam int         PRESCALE_LSB    = 4;
	localparam int         IRQ_RESP_BIT    = 3;
	localparam int         STATUS_BIT      = 2;
	localparam int         ENABLE_BIT      = 1;
	localparam int         UNLOCK_BIT      = 0;

	// Counter geometry and prescale codes.
	localparam int         COUNT_WIDTH     = 16;
	localparam int         BASE_LOG2       = 9;
	localparam logic [3:0] PRESCALE_MAX    = 4'h7;
	localparam logic [3:0] PRESCALE_IMMED  = 4'h8;

	// Crystal and core clock rates; the crystal arrives as a sampled level.
	localparam int         XTAL_HZ         = 32768;
	localparam int         MCLK_HZ         = 125000000;

endpackage : wdt_pkg

//--- verilog/wdt_count.sv
`timescale 1ns/10ps
`default_nettype none

module wdt_count #(
	parameter int CW = wdt_pkg::COUNT_WIDTH
) (
	input  wire logic        mclk,      // Core clock.
	input  wire logic        rst_n,     // Synchronous reset, active low.
	input  wire logic        tick,      // One crystal period elapsed.
	input  wire logic        clear,     // Restart the count.
	input  wire logic [3:0]  prescale,  // Timeout prescale code.
	output logic             expire     // One-cycle timeout pulse.
);

	logic [CW-1:0] count_q;

	// Terminal count is 2^(prescale+9) crystal periods minus one.
	function automatic logic [CW-1:0] limitOf(input logic [3:0] pre);
		logic [CW:0] one;
		one = {{CW{1'b0}}, 1'b1};
		limitOf = CW'((one << (pre + wdt_pkg::BASE_LOG2)) - one);
	endfunction

	wire logic validPre = prescale <= wdt_pkg::PRESCALE_MAX;
	wire logic atLimit  = count_q == limitOf(prescale);

	always_ff @(posedge mclk) begin
		if (!rst_n || clear || !validPre) begin
			count_q <= '0;
		end else if (tick) begin
			count_q <= atLimit ? '0 : CW'(count_q + 1'b1); // [RL3] [RL4]
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			expire <= 1'b0;
		end else begin
			expire <= tick && atLimit && validPre && !clear; // [RL4]
		end
	end

	terminal_only_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
		expire |-> $past(count_q) == limitOf($past(prescale)) && $past(tick))
		else $error("timeout pulse without terminal count");

endmodule // wdt_count

`default_nettype wire

//--- verilog/wdt_top.sv
// Overview of operation
// [RL1] Cleared enable stops all watchdog action.
// [RL2] Refresh enable before timeout, else reset/interrupt.
// [RL3] Sixteen-bit counter advanced by crystal periods.
// [RL4] Timeout is 2^prescale times 2^9 periods.
// [RL5] Prescale 0-7 timed, 8 immediate reset.
// [RL6] Response bit selects interrupt instead of reset.
// [RL7] Watchdog interrupt ignores global interrupt enable.
// [RL8] Status sets on timeout, survives watchdog reset.
// [RL9] Enable clears on zero write, reset, interrupt.
// [RL10] Writes accepted only right after unlock instruction.
// [RL11] Software sets unlock in separate preceding instruction.
// [RL12] Power-on register value is 10H.
// [RL13] Unlock permission lapses after one following instruction.
`timescale 1ns/10ps
`default_nettype none

module wdt_top (
	input  wire logic        mclk,        // Core clock, 125 MHz.
	input  wire logic        rst_n,       // External hardware reset, active low.
	input  wire logic        xtalClk,     // Crystal level, sampled on mclk.
	input  wire logic        instrEnd,    // Pulse at the end of each instruction.
	input  wire logic [7:0]  sfrAddr,     // Register address.
	input  wire logic        sfrWrEn,     // Byte write strobe.
	input  wire logic [7:0]  sfrWrData,   // Byte write data.
	input  wire logic        sfrBitWrEn,  // Single-bit write strobe.
	input  wire logic [2:0]  sfrBitSel,   // Bit index for a bit write.
	input  wire logic        sfrBitVal,   // Value for a bit write.
	input  wire logic        sfrRdEn,     // Read strobe.
	output logic      [7:0]  sfrRdData,   // Read data, one cycle after strobe.
	output logic             wdtResetReq, // One-cycle system reset request.
	output logic             wdtIrq       // One-cycle interrupt request.
);

	////////////////////////////////////////////////////////////////////////////
	// Register access decode.

	logic [7:1] ctrl_q;
	logic       unlock_q;
	logic       armed_q;
	logic       xtalPrev_q;
	logic       expire;

	wire logic [7:0] ctrlView = {ctrl_q, unlock_q};
	wire logic       addrHit  = sfrAddr == wdt_pkg::WDT_CTRL_ADDR;
	wire logic       wrHit    = addrHit && (sfrWrEn || sfrBitWrEn);

	function automatic logic [7:0] mergeBit(input logic [7:0] cur, input logic [2:0] sel,
			input logic val);
		logic [7:0] res;
		res = cur;
		res[sel] = val;
		mergeBit = res;
	endfunction

	wire logic [7:0] wData  = sfrWrEn ? sfrWrData : mergeBit(ctrlView, sfrBitSel, sfrBitVal);
	wire logic       wrOk   = wrHit && armed_q; // [RL10]
	wire logic [3:0] pre    = ctrl_q[wdt_pkg::PRESCALE_MSB:wdt_pkg::PRESCALE_LSB];
	wire logic       enable = ctrl_q[wdt_pkg::ENABLE_BIT];
	wire logic       irqSel = ctrl_q[wdt_pkg::IRQ_RESP_BIT];
	wire logic       immed  = enable && pre == wdt_pkg::PRESCALE_IMMED; // [RL5]
	wire logic       fire   = enable && (expire || immed); // [RL1] [RL2]
	wire logic       tick   = xtalClk && !xtalPrev_q;

	////////////////////////////////////////////////////////////////////////////
	// Crystal period detection; one clock domain, crystal edges become enables.

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			xtalPrev_q <= 1'b0;
		end else begin
			xtalPrev_q <= xtalClk;
		end
	end

	// Writing one to the enable bit is the refresh; disabling also clears the count.
	wdt_count #(
		.CW       (wdt_pkg::COUNT_WIDTH)
	) uCount (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.tick     (tick),
		.clear    (!enable || fire || (wrOk && wData[wdt_pkg::ENABLE_BIT])), // [RL2] [RL3]
		.prescale (pre),
		.expire   (expire)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write unlock. The unlock is armed when its setting instruction ends and
	// lapses when the next instruction ends, so a stray later write is refused.

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			unlock_q <= 1'b0;
			armed_q  <= 1'b0;
		end else if (wrOk) begin
			unlock_q <= 1'b0;
			armed_q  <= 1'b0;
		end else if (wrHit && wData[wdt_pkg::UNLOCK_BIT]) begin
			unlock_q <= 1'b1; // [RL11]
			armed_q  <= 1'b0;
		end else if (instrEnd && unlock_q) begin
			unlock_q <= !armed_q; // [RL13]
			armed_q  <= !armed_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control bits. A timeout outranks a write in the same cycle, so the status
	// flag can never be lost to a concurrent software clear.

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q <= wdt_pkg::WDT_CTRL_RESET[7:1]; // [RL12]
		end else if (fire && irqSel) begin
			ctrl_q[wdt_pkg::ENABLE_BIT] <= 1'b0; // [RL9]
			ctrl_q[wdt_pkg::STATUS_BIT] <= 1'b1; // [RL8]
		end else if (fire) begin
			ctrl_q                      <= wdt_pkg::WDT_CTRL_RESET[7:1]; // [RL9]
			ctrl_q[wdt_pkg::STATUS_BIT] <= 1'b1; // [RL8]
		end else if (wrOk) begin
			ctrl_q <= wData[7:1]; // [RL10]
		end
	end

	// The interrupt bypasses the core's global enable: no such gate exists here.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wdtResetReq <= 1'b0;
			wdtIrq      <= 1'b0;
		end else begin
			wdtResetReq <= fire && (!irqSel || immed); // [RL2] [RL5]
			wdtIrq      <= fire && irqSel && !immed; // [RL6] [RL7]
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sfrRdData <= 8'h00;
		end else begin
			sfrRdData <= (sfrRdEn && addrHit) ? ctrlView : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	disabled_quiet_a: assert property ( // [RL1]
		!enable |=> !wdtResetReq && !wdtIrq)
		else $error("watchdog acted while disabled");
	reset_mode_a: assert property ( // [RL2]
		expire && enable && !irqSel |=> wdtResetReq && !wdtIrq)
		else $error("timeout without reset in reset mode");
	immediate_reset_a: assert property ( // [RL5]
		immed |=> wdtResetReq && !enable)
		else $error("prescale eight did not reset");
	irq_mode_a: assert property ( // [RL6]
		fire && irqSel && !immed |=> wdtIrq && !wdtResetReq && !enable)
		else $error("interrupt mode misbehaved");
	status_set_a: assert property ( // [RL8]
		fire |=> ctrl_q[wdt_pkg::STATUS_BIT] ##1 (ctrl_q[wdt_pkg::STATUS_BIT] || $past(wrOk)))
		else $error("status not set on timeout");
	locked_write_a: assert property ( // [RL10]
		wrHit && !armed_q && !fire |=> $stable(ctrl_q))
		else $error("locked write changed control");
	unlock_lapse_a: assert property ( // [RL13]
		armed_q && instrEnd && !wrHit |=> !unlock_q && !armed_q)
		else $error("unlock outlived its instruction");
	// Reset is the condition under test here, so this check alone is never disabled.
	power_on_a: assert property (@(posedge mclk) disable iff (1'b0) // [RL12]
		!rst_n |=> ctrlView == wdt_pkg::WDT_CTRL_RESET)
		else $error("wrong reset value");

	// Every action clears the enable bit, so neither request can last two cycles.
	single_pulse_a: assert property ( // [RL2]
		wdtResetReq || wdtIrq |=> !wdtResetReq && !wdtIrq)
		else $error("watchdog request lasted two cycles");
	request_cause_a: assert property ( // [RL1]
		wdtResetReq || wdtIrq |-> $past(fire))
		else $error("watchdog request without a cause");
	one_request_a: assert property ( // [RL6]
		!(wdtResetReq && wdtIrq))
		else $error("reset and interrupt requested together");
	enable_clear_a: assert property ( // [RL9]
		fire |=> !enable)
		else $error("enable survived a watchdog action");
	reset_restore_a: assert property ( // [RL9]
		fire && !irqSel |=> pre == wdt_pkg::WDT_CTRL_RESET[7:4] && !irqSel && !enable)
		else $error("watchdog reset left control fields set");
	irq_keep_a: assert property ( // [RL6]
		fire && irqSel |=> pre == $past(pre) && irqSel)
		else $error("interrupt response lost control fields");

	// Status only moves on a timeout or an accepted write; a hardware reset also clears it.
	status_rise_a: assert property ( // [RL8]
		$rose(ctrl_q[wdt_pkg::STATUS_BIT]) |-> $past(fire) || $past(wrOk))
		else $error("status rose without a timeout");
	status_fall_a: assert property ( // [RL8]
		$fell(ctrl_q[wdt_pkg::STATUS_BIT]) |-> $past(wrOk) || !$past(rst_n))
		else $error("status fell without a write");
	unlock_set_a: assert property ( // [RL10]
		wrHit && !armed_q && wData[wdt_pkg::UNLOCK_BIT] |=> unlock_q)
		else $error("unlock request not taken");
	write_lands_a: assert property ( // [RL10]
		wrOk && !fire |=> ctrl_q == $past(wData[7:1]))
		else $error("unlocked write did not land");
	read_data_a: assert property ( // [RL12]
		sfrRdEn && addrHit |=> sfrRdData == $past(ctrlView))
		else $error("read data differs from control");
	read_idle_a: assert property ( // [RL12]
		!(sfrRdEn && addrHit) |=> sfrRdData == 8'h00)
		else $error("read data not idle");

	irq_seen_c: cover property (wdtIrq);
	reset_seen_c: cover property (wdtResetReq && !$past(immed));
	unlocked_write_c: cover property (wrOk && wData[wdt_pkg::ENABLE_BIT]);
	refused_write_c: cover property (wrHit && !armed_q && !wData[wdt_pkg::UNLOCK_BIT]);
	bit_refresh_c: cover property (wrOk && sfrBitWrEn && !sfrWrEn && wData[wdt_pkg::ENABLE_BIT]);

endmodule // wdt_top

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       mclk = 1'b0, rst_n = 1'b0, xtalClk = 1'b0, instrEnd = 1'b0;
	logic [7:0] sfrAddr = 8'hC0, sfrWrData = 8'h00;
	logic       sfrWrEn = 1'b0, sfrBitWrEn = 1'b0, sfrBitVal = 1'b0, sfrRdEn = 1'b0;
	logic [2:0] sfrBitSel = 3'h0;
	logic [7:0] sfrRdData;
	logic       wdtResetReq, wdtIrq;
	int         nFail = 0, nChecks = 0, nRst = 0, nIrq = 0, cyc = 0;

	wdt_top DUT (.mclk(mclk), .rst_n(rst_n), .xtalClk(xtalClk), .instrEnd(instrEnd),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrBitWrEn(sfrBitWrEn),
		.sfrBitSel(sfrBitSel), .sfrBitVal(sfrBitVal), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .wdtResetReq(wdtResetReq), .wdtIrq(wdtIrq));

	always #4 mclk = ~mclk;

	// Pulses last one cycle, so they are counted at every edge rather than polled.
	always @(posedge mclk) begin
		cyc++;
		if (wdtResetReq === 1'b1) nRst++;
		if (wdtIrq === 1'b1) nIrq++;
		if (cyc == 60000) begin
			nFail++;
			endSim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic endSim;
		if (nFail == 0 && nChecks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nChecks++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic ie;
		instrEnd = 1'b1;
		step;
		instrEnd = 1'b0;
	endtask

	task automatic wr(input logic [7:0] d);
		sfrWrData = d;
		sfrWrEn = 1'b1;
		step;
		sfrWrEn = 1'b0;
	endtask

	task automatic bw(input logic [2:0] s, input logic v);
		sfrBitSel = s;
		sfrBitVal = v;
		sfrBitWrEn = 1'b1;
		step;
		sfrBitWrEn = 1'b0;
	endtask

	task automatic unlock;
		bw(3'h0, 1'b1);
	endtask

	// Unlock by bit write, end that instruction, then the byte write and its end.
	task automatic uwr(input logic [7:0] d);
		unlock;
		ie;
		wr(d);
		ie;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		step;
		sfrRdEn = 1'b0;
		sfrAddr = 8'hC0;
		chk(sfrRdData, exp);
		// An idle cycle keeps the next request off the time step of this release.
		step;
	endtask

	// Four core cycles per crystal period keep the edge detector well fed.
	task automatic tick(input int n);
		repeat (n) begin
			xtalClk = 1'b1;
			repeat (2) step;
			xtalClk = 1'b0;
			repeat (2) step;
		end
		repeat (8) step;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic sReset;
		rd(8'hC0, 8'h10);
		rd(8'hC1, 8'h00);
		tick(600);
		chk(8'(nRst + nIrq), 8'h00);
	endtask

	task automatic sLock;
		wr(8'h72);
		ie;
		rd(8'hC0, 8'h10);
		unlock;
		ie;
		step;
		ie;
		wr(8'h72);
		ie;
		rd(8'hC0, 8'h10);
		uwr(8'h70);
		rd(8'hC0, 8'h70);
	endtask

	// The refresh after 300 crystal periods must restart the full count.
	task automatic sTimeout(input logic [3:0] p);
		int total;
		total = 512 << p;
		nRst = 0;
		uwr({p, 4'h2});
		tick(300);
		uwr({p, 4'h2});
		tick(total - 1);
		chk(8'(nRst), 8'h00);
		tick(1);
		chk(8'(nRst), 8'h01);
		rd(8'hC0, 8'h14);
		uwr(8'h10);
		rd(8'hC0, 8'h10);
	endtask

	task automatic sReserved;
		nRst = 0;
		uwr(8'h92);
		tick(600);
		chk(8'(nRst + nIrq), 8'h00);
		uwr(8'h10);
	endtask

	task automatic sIrq;
		nRst = 0;
		nIrq = 0;
		uwr(8'h0A);
		tick(511);
		chk(8'(nIrq), 8'h00);
		tick(1);
		chk(8'(nIrq), 8'h01);
		chk(8'(nRst), 8'h00);
		rd(8'hC0, 8'h0C);
	endtask

	task automatic sImmed;
		nRst = 0;
		uwr(8'h82);
		repeat (4) step;
		chk(8'(nRst), 8'h01);
		rd(8'hC0, 8'h14);
	endtask

	// Bit writes after unlock: setting enable refreshes, clearing status clears it.
	task automatic sBitWr;
		nRst = 0;
		uwr(8'h02);
		tick(300);
		unlock;
		ie;
		bw(3'h1, 1'b1);
		ie;
		tick(511);
		chk(8'(nRst), 8'h00);
		tick(1);
		chk(8'(nRst), 8'h01);
		unlock;
		ie;
		bw(3'h2, 1'b0);
		ie;
		rd(8'hC0, 8'h10);
	endtask

	// A hardware reset in mid-run must clear the status that a watchdog reset kept.
	task automatic sHwReset;
		rst_n = 1'b0;
		repeat (3) step;
		rst_n = 1'b1;
		rd(8'hC0, 8'h10);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		sReset;
		sLock;
		sTimeout(4'h0);
		sTimeout(4'h1);
		sBitWr;
		sReserved;
		sIrq;
		sImmed;
		sHwReset;
		endSim();
	end
endmodule // tb
`default_nettype wire
